/* verilog/cgs_generator.sv */
// Purpose: Clock generator start-up, source control and register slave
// Assumes: Supply and oscillator status arrive as asynchronous levels
// Notes:   Registers reached over Avalon-MM with waitrequest

`timescale 1ns/1ps

// How it works
// - Fast internal oscillator starts after reset alone
// - CPU runs on fast clock first
// - Slow oscillator never becomes CPU clock
// - Option decides if slow oscillator stops
// - Slow oscillator and watchdog start after reset
// - Prescaler divides main clock when selected
// - Reset held until supply crosses threshold
// - Voltage stabilization wait before reset processing
// - Software starts crystals, switches after stabilization
// - External clock inputs need no wait
// - Software checks status, programs stop wait
// - Unused clocks stoppable; stop halts fast, main
// - Software clears subclock pin mode when unused
// - Slow ramps need reset pin or dual mode
// - Stabilization status clears, then fills in order
// - Select register resets to five, five codes
module cgs_generator #(
  parameter int VOLT_WAIT_CYC = cgs_pkg::STAB_WAIT_MIN_CYC
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Supply and option inputs
  input  wire logic        supply_ok,
  input  wire logic        supply_fast_ramp,
  input  wire logic        poc_threshold_option,
  input  wire logic        slow_osc_stoppable,
  // Oscillator status inputs
  input  wire logic        main_osc_tick,
  input  wire logic        main_ext_clock_sel,
  input  wire logic        sub_osc_ready,
  // Oscillator enables
  output logic             fast_osc_en,
  output logic             slow_osc_en,
  output logic             main_osc_en,
  output logic             sub_osc_en,
  output logic             subclock_pin_mode_select,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Link to consumers
  cgs_link_if.gen          link
);
  import cgs_pkg::*;

  cgs_state_type state;
  logic [1:0]  supply_sync, ramp_sync, sub_sync, ext_sync, tick_sync;
  logic        tick_d;
  logic [22:0] wait_cnt;
  logic [7:0]  ctrl;
  logic [2:0]  stab_time_select;
  cgs_src_type req_src;
  logic [1:0]  switch_cnt;
  logic [4:0]  stab_status;
  logic        stab_done;
  logic        stab_clear;
  logic        bus_ack;
  logic [7:0]  presc;
  logic        main_ready;

  // Two-flop synchronisers for pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      supply_sync <= 2'h0;
      ramp_sync   <= 2'h0;
      sub_sync    <= 2'h0;
      ext_sync    <= 2'h0;
      tick_sync   <= 2'h0;
      tick_d      <= 1'b0;
    end else begin
      supply_sync <= {supply_sync[0], supply_ok};
      ramp_sync   <= {ramp_sync[0], supply_fast_ramp};
      sub_sync    <= {sub_sync[0], sub_osc_ready};
      ext_sync    <= {ext_sync[0], main_ext_clock_sel};
      tick_sync   <= {tick_sync[0], main_osc_tick};
      tick_d      <= tick_sync[1];
    end
  end

  // Start-up sequence
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state    <= CGS_POR_HOLD;
      wait_cnt <= '0;
    end else begin
      case (state)
        CGS_POR_HOLD: begin
          wait_cnt <= '0;
          if (supply_sync[1]) state <= CGS_VOLT_WAIT;
        end
        CGS_VOLT_WAIT: begin
          wait_cnt <= wait_cnt + 1'b1;
          if (!supply_sync[1]) state <= CGS_POR_HOLD;
          else if (ramp_sync[1] ||
                   wait_cnt >= 23'(VOLT_WAIT_CYC - 1))
            state <= CGS_RESET_PROC;
        end
        CGS_RESET_PROC: state <= CGS_RUN;
        CGS_RUN: begin
          if (!supply_sync[1]) state <= CGS_POR_HOLD;
          else if (link.stop_req) state <= CGS_STOPPED;
        end
        CGS_STOPPED: begin
          if (!supply_sync[1]) state <= CGS_POR_HOLD;
          else if (!link.stop_req) state <= CGS_RUN;
        end
        default: state <= CGS_POR_HOLD;
      endcase
    end
  end

  assign main_ready = ext_sync[1] || stab_done;

  // Control registers written over the bus
  always_ff @(posedge sys_clk) begin
    if (rst || state == CGS_POR_HOLD) begin
      ctrl             <= CTRL_RESET;
      stab_time_select <= STS_RESET;
      req_src          <= CGS_SRC_FAST;
    end else if (avs_write && bus_ack) begin
      case (avs_address)
        REG_CTRL: begin
          ctrl <= avs_writedata[7:0];
          if (!slow_osc_stoppable) ctrl[CTRL_SLOW_STOP] <= 1'b0;
        end
        REG_CPUSEL: begin
          if (avs_writedata[1:0] == 2'h1 ||
              avs_writedata[1:0] == 2'h2 || avs_writedata[1:0] == 2'h0)
            req_src <= cgs_src_type'(avs_writedata[1:0]);
        end
        REG_STS_SEL: begin
          if (avs_writedata[2:0] >= STS_MIN &&
              avs_writedata[2:0] <= STS_MAX)
            stab_time_select <= avs_writedata[2:0];
        end
        default: ;
      endcase
    end
  end

  // One-cycle wait then acknowledge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_ack      <= 1'b0;
      avs_readdata <= 32'h0;
    end else begin
      bus_ack <= (avs_read || avs_write) && !bus_ack;
      case (avs_address)
        REG_CTRL:    avs_readdata <= {24'h0, ctrl};
        REG_CPUSEL:  avs_readdata <= {24'h0, 3'h0, state == CGS_RUN,
                                      link.cpu_src, req_src};
        REG_STS_SEL: avs_readdata <= {29'h0, stab_time_select};
        REG_STATUS:  avs_readdata <= {24'h0, sub_sync[1], main_ready,
                                      1'b0, stab_status};
        default:     avs_readdata <= 32'h0;
      endcase
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

  assign stab_clear = (state != CGS_RUN) || ctrl[CTRL_MAIN_STOP];

  cgs_stab_counter u_stab (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .clear     (stab_clear),
    .main_tick (tick_sync[1] && !tick_d),
    .select    (stab_time_select),
    .status    (stab_status),
    .done      (stab_done)
  );

  // Oscillator enables
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fast_osc_en <= 1'b0;
      slow_osc_en <= 1'b0;
      main_osc_en <= 1'b0;
      sub_osc_en  <= 1'b0;
      subclock_pin_mode_select <= 1'b0;
    end else begin
      // Fast runs from release unless stopped or software stops it unused
      fast_osc_en <= (state == CGS_VOLT_WAIT || state == CGS_RESET_PROC ||
                      (state == CGS_RUN && (!ctrl[CTRL_FAST_STOP] ||
                       link.cpu_src == CGS_SRC_FAST)));
      slow_osc_en <= (state != CGS_POR_HOLD) &&
                     !(slow_osc_stoppable && ctrl[CTRL_SLOW_STOP]);
      main_osc_en <= (state == CGS_RUN) && (!ctrl[CTRL_MAIN_STOP] ||
                      link.cpu_src == CGS_SRC_MAIN);
      sub_osc_en  <= (state != CGS_POR_HOLD) && (ctrl[CTRL_SUB_RUN] ||
                      link.cpu_src == CGS_SRC_SUB);
      subclock_pin_mode_select <= ctrl[CTRL_SUB_PIN_MODE];
    end
  end

  // Glitch-free switch: gate clock two cycles, then change source
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.cpu_src    <= CGS_SRC_FAST;
      link.cpu_clk_en <= 1'b0;
      switch_cnt      <= 2'h0;
    end else if (state != CGS_RUN) begin
      // Gate first, fall back to fast only once the gate is shut
      link.cpu_clk_en <= 1'b0;
      switch_cnt      <= 2'h0;
      if (!link.cpu_clk_en) link.cpu_src <= CGS_SRC_FAST;
    end else if (req_src != link.cpu_src &&
                 ((req_src == CGS_SRC_MAIN && main_ready) ||
                  (req_src == CGS_SRC_SUB && sub_sync[1]) ||
                  req_src == CGS_SRC_FAST)) begin
      link.cpu_clk_en <= 1'b0;
      switch_cnt      <= switch_cnt + 1'b1;
      if (switch_cnt == 2'(SYNC_SETTLE_CYC)) begin
        link.cpu_src <= req_src;
        switch_cnt   <= 2'h0;
      end
    end else begin
      link.cpu_clk_en <= 1'b1;
      switch_cnt      <= 2'h0;
    end
  end

  // Prescaler on main system clock
  always_ff @(posedge sys_clk) begin
    if (rst || link.cpu_src != CGS_SRC_MAIN) begin
      presc              <= 8'h0;
      link.prescale_tick <= 5'h0;
    end else begin
      presc              <= presc + 1'b1;
      link.prescale_tick <= {presc[4:0] == 5'h1f, presc[3:0] == 4'hf,
                             presc[2:0] == 3'h7, presc[1:0] == 2'h3,
                             presc[0]};
    end
  end

  // Reset and clock enables toward consumers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link.cpu_reset_n   <= 1'b0;
      link.periph_clk_en <= 1'b0;
      link.wdt_clk_en    <= 1'b0;
      link.tmr8_clk_en   <= 1'b0;
      link.cpu_running   <= 1'b0;
    end else begin
      link.cpu_reset_n   <= (state == CGS_RUN || state == CGS_STOPPED);
      link.periph_clk_en <= (state == CGS_RUN);
      link.wdt_clk_en    <= slow_osc_en;
      link.tmr8_clk_en   <= slow_osc_en;
      link.cpu_running   <= (state == CGS_RUN) && link.cpu_clk_en;
    end
  end

endmodule : cgs_generator

/* verilog/cgs_pkg.sv */
// Purpose: Shared constants and types for the clock generator start-up block
// Assumes: sys_clk at 100 MHz; oscillators modelled as enable/ready levels
// Notes:   Software side reaches the controller over Avalon-MM

package cgs_pkg;

  // Clock rate and timing
  localparam int SYS_CLK_HZ           = 100_000_000;
  localparam int STAB_WAIT_MIN_US     = 1930;  // 1.93 ms in microseconds
  localparam int STAB_WAIT_MAX_US     = 5390;  // 5.39 ms in microseconds
  localparam int STAB_WAIT_MIN_CYC    = (STAB_WAIT_MIN_US * 100);
  localparam int STAB_WAIT_MAX_CYC    = (STAB_WAIT_MAX_US * 100);
  localparam int FAST_OSC_HZ          = 8_000_000;
  localparam int SLOW_OSC_HZ          = 240_000;
  localparam int SYNC_SETTLE_CYC      = 2;

  // Stabilization time select codes and reset value
  localparam logic [2:0] STS_RESET    = 3'h5;
  localparam logic [2:0] STS_MIN      = 3'h1;
  localparam logic [2:0] STS_MAX      = 3'h5;
  localparam logic [4:0] STAB_STATUS_RESET = 5'h00;
  localparam int STAB_CNT_W           = 17;

  // Exponents for stabilization status bits (bit4 = 2^11 .. bit0 = 2^16)
  localparam int STAB_EXP0 = 11;
  localparam int STAB_EXP1 = 13;
  localparam int STAB_EXP2 = 14;
  localparam int STAB_EXP3 = 15;
  localparam int STAB_EXP4 = 16;

  // Register offsets (byte addresses) of the controller's own map
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_CPUSEL   = 4'h4;
  localparam logic [3:0] REG_STS_SEL  = 4'h8;
  localparam logic [3:0] REG_STATUS   = 4'hc;

  // Control register bit positions
  localparam int CTRL_MAIN_STOP       = 0;
  localparam int CTRL_SUB_RUN         = 1;
  localparam int CTRL_FAST_STOP       = 2;
  localparam int CTRL_SLOW_STOP       = 3;
  localparam int CTRL_SUB_PIN_MODE    = 4;
  localparam int CTRL_STOP_CMD        = 5;
  localparam int CTRL_PRESCALE_LSB    = 8;
  localparam logic [7:0] CTRL_RESET   = 8'h01;

  // CPU clock sources; the slow internal oscillator is deliberately absent
  typedef enum logic [1:0] {
    CGS_SRC_FAST = 2'h0,
    CGS_SRC_MAIN = 2'h1,
    CGS_SRC_SUB  = 2'h2
  } cgs_src_type;

  // Start-up sequence states
  typedef enum logic [2:0] {
    CGS_POR_HOLD,
    CGS_VOLT_WAIT,
    CGS_RESET_PROC,
    CGS_RUN,
    CGS_STOPPED
  } cgs_state_type;

endpackage : cgs_pkg

/* verilog/cgs_link_if.sv */
// Purpose: Link between the clock generator and its clock consumers
// Assumes: One system clock; enables and ready levels stand in for clocks
// Notes:   gen modport is the generator, cons modport the CPU side

`timescale 1ns/1ps

interface cgs_link_if;
  import cgs_pkg::*;
  logic        cpu_reset_n;
  logic        cpu_clk_en;
  cgs_src_type cpu_src;
  logic        periph_clk_en;
  logic [4:0]  prescale_tick;
  logic        wdt_clk_en;
  logic        tmr8_clk_en;
  logic        stop_req;
  logic        cpu_running;

  modport gen  (output cpu_reset_n, cpu_clk_en, cpu_src, periph_clk_en,
                prescale_tick, wdt_clk_en, tmr8_clk_en, cpu_running,
                input stop_req);
  modport cons (input cpu_reset_n, cpu_clk_en, cpu_src, periph_clk_en,
                prescale_tick, wdt_clk_en, tmr8_clk_en, cpu_running,
                output stop_req);
endinterface : cgs_link_if

/* verilog/cgs_stab_counter.sv */
// Purpose: Main oscillator stabilization counter and status bits
// Assumes: main_tick pulses once per main oscillator cycle, same clock
// Notes:   Status bits fill from the 2^11 bit and stay set

`timescale 1ns/1ps

module cgs_stab_counter (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       clear,
  input  wire logic       main_tick,
  input  wire logic [2:0] select,
  // Status
  output logic [4:0]      status,
  output logic            done
);
  import cgs_pkg::*;

  logic [STAB_CNT_W-1:0] count;
  logic [4:0]            next_status;
  logic [2:0]            limit_bits;

  // Count main oscillator cycles, restart on clear
  always_ff @(posedge sys_clk) begin
    if (rst || clear) begin
      count <= '0;
    end else if (main_tick && !count[STAB_CNT_W-1]) begin
      count <= count + 1'b1;
    end
  end

  // Number of status bits allowed by the select code
  always_comb begin
    case (select)
      3'h1:    limit_bits = 3'h1;
      3'h2:    limit_bits = 3'h2;
      3'h3:    limit_bits = 3'h3;
      3'h4:    limit_bits = 3'h4;
      default: limit_bits = 3'h5;
    endcase
  end

  // Per-bit threshold compare, bit 4 is the shortest wait
  localparam int EXPS [5] = '{STAB_EXP4, STAB_EXP3, STAB_EXP2,
                              STAB_EXP1, STAB_EXP0};
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_bit
      assign next_status[gi] = status[gi] ||
        ((count >= (STAB_CNT_W'(1) << EXPS[gi])) &&
         ((3'(4 - gi)) < limit_bits));
    end
  endgenerate

  // Sticky status, cleared by reset, stop or main stop
  always_ff @(posedge sys_clk) begin
    if (rst || clear) begin
      status <= STAB_STATUS_RESET;
      done   <= 1'b0;
    end else begin
      status <= next_status;
      done   <= next_status[3'(5) - limit_bits];
    end
  end

endmodule : cgs_stab_counter

/* verilog/cgs_consumer.sv */
// Purpose: CPU-side end of the clock link
// Assumes: Same sys_clk as the generator
// Notes:   Issues stop requests, counts CPU cycles

`timescale 1ns/1ps

module cgs_consumer (
  // Clock and reset
  input  wire logic  sys_clk,
  input  wire logic  rst,
  // User side
  input  wire logic  stop_cmd,
  input  wire logic  wake_cmd,
  output logic       in_reset,
  output logic       on_fast_clock,
  output logic [7:0] cpu_cycles,
  // Link to generator
  cgs_link_if.cons   link
);
  import cgs_pkg::*;

  // Stop request held until wake
  always_ff @(posedge sys_clk) begin
    if (rst || !link.cpu_reset_n) begin
      link.stop_req <= 1'b0;
    end else if (wake_cmd) begin
      link.stop_req <= 1'b0;
    end else if (stop_cmd && link.cpu_running) begin
      link.stop_req <= 1'b1;
    end
  end

  // Status toward the user
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      in_reset      <= 1'b1;
      on_fast_clock <= 1'b0;
      cpu_cycles    <= 8'h0;
    end else begin
      in_reset      <= !link.cpu_reset_n;
      on_fast_clock <= link.cpu_src == CGS_SRC_FAST;
      if (link.cpu_clk_en && link.cpu_running) cpu_cycles <= cpu_cycles + 1'b1;
    end
  end

endmodule : cgs_consumer

/* bench/cgs_link_assertions.sv */
// Purpose: Checks on the link between clock generator and consumer
// Assumes: One sys_clk domain; rst synchronous, active high
// Notes:   Takes the interface signals as plain inputs

`timescale 1ns/1ps

module cgs_link_assertions (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst,
  // Link signals
  input wire logic                 cpu_reset_n,
  input wire logic                 cpu_clk_en,
  input wire cgs_pkg::cgs_src_type cpu_src,
  input wire logic                 wdt_clk_en,
  input wire logic                 tmr8_clk_en,
  input wire logic                 stop_req,
  input wire logic                 cpu_running
);
  import cgs_pkg::*;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Source encodings exclude the slow oscillator
  property p_src_legal;
    cpu_src inside {CGS_SRC_FAST, CGS_SRC_MAIN, CGS_SRC_SUB};
  endproperty
  a_src_legal: assert property (p_src_legal)
    else $error("cpu source outside legal set");

  // CPU leaves reset on the fast internal clock
  property p_fast_first;
    $rose(cpu_reset_n) |-> cpu_src == CGS_SRC_FAST;
  endproperty
  a_fast_first: assert property (p_fast_first)
    else $error("cpu left reset on a slow source");

  // Clock reaches the CPU soon after release
  property p_clk_after_release;
    $rose(cpu_reset_n) |-> ##[0:3] cpu_clk_en;
  endproperty
  a_clk_after_release: assert property (p_clk_after_release)
    else $error("no cpu clock after reset release");

  // CPU runs without waiting for crystals
  property p_run_after_release;
    $rose(cpu_reset_n) |-> ##[0:4] cpu_running;
  endproperty
  a_run_after_release: assert property (p_run_after_release)
    else $error("cpu not running after release");

  // No execution while reset holds
  property p_no_run_in_reset;
    !cpu_reset_n |-> !cpu_running;
  endproperty
  a_no_run_in_reset: assert property (p_no_run_in_reset)
    else $error("cpu running during reset");

  // Watchdog clock starts with reset release
  property p_wdt_start;
    $rose(cpu_reset_n) |-> ##[0:2] wdt_clk_en;
  endproperty
  a_wdt_start: assert property (p_wdt_start)
    else $error("watchdog clock missing after release");

  // Timer and watchdog share the slow oscillator
  property p_tmr8_slow;
    tmr8_clk_en == wdt_clk_en;
  endproperty
  a_tmr8_slow: assert property (p_tmr8_slow)
    else $error("timer clock differs from watchdog clock");

  // Source changes only while the CPU clock is gated
  property p_switch_gated;
    $changed(cpu_src) |-> !$past(cpu_clk_en);
  endproperty
  a_switch_gated: assert property (p_switch_gated)
    else $error("cpu source changed with clock enabled");

  // Stop request halts the CPU clock
  property p_stop_halts;
    stop_req && cpu_running |-> ##[1:3] !cpu_clk_en;
  endproperty
  a_stop_halts: assert property (p_stop_halts)
    else $error("cpu clock kept after stop request");

  // Main scenarios reached
  c_release: cover property ($rose(cpu_reset_n));
  c_switch: cover property ($changed(cpu_src));
  c_stop: cover property (stop_req && cpu_running);
endmodule : cgs_link_assertions

/* bench/clock_generator_startup_bench.sv */
// Purpose: Self-checking bench for generator and consumer together
// Assumes: 100 MHz sys_clk; short voltage wait for simulation
// Notes:   Registers reached over Avalon-MM with waitrequest

`timescale 1ns/1ps

module clock_generator_startup_bench;
  import cgs_pkg::*;
  logic        sys_clk, rst, supply_ok, slow_osc_stoppable, main_osc_tick;
  logic        supply_fast_ramp, wake_cmd, main_ext_sel, sub_osc_en;
  logic        sub_pin_mode;
  logic [7:0]  cpu_cycles, cyc_seen;
  logic        fast_osc_en, slow_osc_en, main_osc_en, stop_cmd;
  logic        in_reset, on_fast_clock, avs_read, avs_write;
  logic        avs_waitrequest;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, junk;
  int          n_fail, checks_done;

  cgs_link_if cgs_link_if_inst ();

  cgs_generator #(.VOLT_WAIT_CYC(10)) cgs_generator_inst (
    .sys_clk(sys_clk), .rst(rst), .supply_ok(supply_ok),
    .supply_fast_ramp(supply_fast_ramp), .poc_threshold_option(1'b0),
    .slow_osc_stoppable(slow_osc_stoppable),
    .main_osc_tick(main_osc_tick), .main_ext_clock_sel(main_ext_sel),
    .sub_osc_ready(1'b0), .fast_osc_en(fast_osc_en),
    .slow_osc_en(slow_osc_en), .main_osc_en(main_osc_en),
    .sub_osc_en(sub_osc_en), .subclock_pin_mode_select(sub_pin_mode),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link(cgs_link_if_inst));

  cgs_consumer cgs_consumer_inst (
    .sys_clk(sys_clk), .rst(rst), .stop_cmd(stop_cmd), .wake_cmd(wake_cmd),
    .in_reset(in_reset), .on_fast_clock(on_fast_clock),
    .cpu_cycles(cpu_cycles), .link(cgs_link_if_inst));

  cgs_link_assertions cgs_link_assertions_inst (
    .sys_clk(sys_clk), .rst(rst),
    .cpu_reset_n(cgs_link_if_inst.cpu_reset_n),
    .cpu_clk_en(cgs_link_if_inst.cpu_clk_en),
    .cpu_src(cgs_link_if_inst.cpu_src),
    .wdt_clk_en(cgs_link_if_inst.wdt_clk_en),
    .tmr8_clk_en(cgs_link_if_inst.tmr8_clk_en),
    .stop_req(cgs_link_if_inst.stop_req),
    .cpu_running(cgs_link_if_inst.cpu_running));

  // Clock and main oscillator cycles
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) main_osc_tick <= rst ? 1'b0 : ~main_osc_tick;

  task automatic fail(input string s);
    n_fail++;
    $display("unexpected at %0t: %s", $time, s);
  endtask : fail

  task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                     input string s);
    checks_done++;
    if (g !== e) fail(s);
  endtask : cmp

  // One bus transfer, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, junk);
  endtask : wr

  task automatic rd_cmp(input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    bus(1'b0, a, 32'h0, junk);
    cmp(junk & m, e, "register read");
  endtask : rd_cmp

  task automatic wait_src(input cgs_src_type s);
    for (int i = 0; i < 100 && cgs_link_if_inst.cpu_src !== s; i++)
      @(negedge sys_clk);
    cmp({30'h0, cgs_link_if_inst.cpu_src}, {30'h0, s}, "cpu source");
  endtask : wait_src

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim

  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge sys_clk);
    fail("watchdog expired");
    end_sim();
  end

  // Test sequence
  initial begin
    rst = 1'b1;
    supply_ok = 1'b0;
    slow_osc_stoppable = 1'b0;
    supply_fast_ramp = 1'b0;
    main_ext_sel = 1'b0;
    wake_cmd = 1'b0;
    stop_cmd = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (20) @(negedge sys_clk);
    cmp(in_reset, 1'b1, "released without supply");
    @(posedge sys_clk);
    supply_ok <= 1'b1;
    repeat (8) @(negedge sys_clk);
    cmp(in_reset, 1'b1, "voltage wait skipped");
    for (int i = 0; i < 200 && in_reset !== 1'b0; i++) @(negedge sys_clk);
    cmp(on_fast_clock, 1'b1, "cpu not on fast clock");
    cmp(fast_osc_en, 1'b1, "fast oscillator idle");
    cmp(slow_osc_en, 1'b1, "slow oscillator idle");
    cmp(main_osc_en, 1'b0, "crystal started alone");
    $display("test boot done");
    rd_cmp(REG_CTRL, 32'h1f, 32'h01);
    rd_cmp(REG_STATUS, 32'h1f, 32'h00);
    rd_cmp(REG_STS_SEL, 32'h7, 32'h5);
    for (int c = 0; c < 8; c++) begin
      wr(REG_STS_SEL, 32'h3);
      wr(REG_STS_SEL, 32'(c));
      rd_cmp(REG_STS_SEL, 32'h7, (c inside {[1:5]}) ? 32'(c) : 32'h3);
    end
    bus(1'b0, 4'h2, 32'h0, junk);
    $display("test registers done");
    wr(REG_STS_SEL, 32'h1);
    wr(REG_CTRL, 32'h0);
    repeat (1000) @(negedge sys_clk);
    cmp(main_osc_en, 1'b1, "crystal not started");
    rd_cmp(REG_STATUS, 32'h1f, 32'h00);
    repeat (4000) @(negedge sys_clk);
    rd_cmp(REG_STATUS, 32'h5f, 32'h50);
    $display("test stabilization done");
    wr(REG_CPUSEL, 32'h3);
    repeat (10) @(negedge sys_clk);
    wait_src(CGS_SRC_FAST);
    wr(REG_CPUSEL, 32'h1);
    wait_src(CGS_SRC_MAIN);
    rd_cmp(REG_CPUSEL, 32'hc, 32'h4);
    wr(REG_CPUSEL, 32'h0);
    wait_src(CGS_SRC_FAST);
    wr(REG_CTRL, 32'h1);
    rd_cmp(REG_STATUS, 32'h1f, 32'h00);
    cmp(main_osc_en, 1'b0, "crystal not stopped");
    $display("test switch done");
    wr(REG_CTRL, 32'h9);
    repeat (3) @(negedge sys_clk);
    cmp(slow_osc_en, 1'b1, "locked slow oscillator stopped");
    @(posedge sys_clk);
    slow_osc_stoppable <= 1'b1;
    wr(REG_CTRL, 32'h1b);
    repeat (3) @(negedge sys_clk);
    cmp(slow_osc_en, 1'b0, "slow oscillator kept");
    cmp(sub_osc_en, 1'b1, "subsystem oscillator idle");
    cmp(sub_pin_mode, 1'b1, "subsystem pins not in clock mode");
    wr(REG_CTRL, 32'h0);
    repeat (3) @(negedge sys_clk);
    cmp(slow_osc_en, 1'b1, "slow oscillator not restarted");
    cmp(sub_osc_en, 1'b0, "subsystem oscillator kept");
    cmp(sub_pin_mode, 1'b0, "subsystem pins not released");
    $display("test slow oscillator done");
    @(posedge sys_clk);
    stop_cmd <= 1'b1;
    @(posedge sys_clk);
    stop_cmd <= 1'b0;
    repeat (4) @(negedge sys_clk);
    cmp(fast_osc_en, 1'b0, "fast oscillator runs in stop");
    cmp(main_osc_en, 1'b0, "crystal runs in stop");
    cyc_seen = cpu_cycles;
    repeat (4) @(negedge sys_clk);
    cmp(cpu_cycles, cyc_seen, "cpu clock runs in stop");
    @(posedge sys_clk);
    wake_cmd <= 1'b1;
    @(posedge sys_clk);
    wake_cmd <= 1'b0;
    repeat (4) @(negedge sys_clk);
    cmp(fast_osc_en, 1'b1, "fast oscillator not restarted");
    cmp(on_fast_clock, 1'b1, "cpu not back on fast clock");
    $display("test stop done");
    @(posedge sys_clk);
    supply_ok <= 1'b0;
    repeat (8) @(negedge sys_clk);
    cmp(in_reset, 1'b1, "reset not reasserted on supply loss");
    @(posedge sys_clk);
    supply_fast_ramp <= 1'b1;
    supply_ok        <= 1'b1;
    repeat (9) @(negedge sys_clk);
    cmp(in_reset, 1'b0, "voltage wait kept on fast ramp");
    @(posedge sys_clk);
    main_ext_sel <= 1'b1;
    wr(REG_CTRL, 32'h0);
    wr(REG_CPUSEL, 32'h1);
    wait_src(CGS_SRC_MAIN);
    $display("test power cycle done");
    end_sim();
  end
endmodule : clock_generator_startup_bench
